// file: src/pbc_mux_pkg.sv
package pbc_mux_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SYSCFG_OFS   = 8'h00;
    localparam logic [7:0] PINMUX_OFS   = 8'h04;
    localparam logic [7:0] PB_DATA_OFS  = 8'h08;
    localparam logic [7:0] PB_DIR_OFS   = 8'h0C;
    localparam logic [7:0] PC_DATA_OFS  = 8'h10;
    localparam logic [7:0] PC_DIR_OFS   = 8'h14;
    localparam logic [7:0] CAPTURE_OFS  = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_PB_LO_BIT   = 5;
    localparam int CFG_PB_HI_BIT   = 6;
    localparam int CFG_PC_BIT      = 7;
    localparam int MUX_EXTERNAL_INTERRUPT_ONE_EDGE   = 0;
    localparam int MUX_EXTERNAL_INTERRUPT_TWO_EDGE   = 1;
    localparam int MUX_STROBE_BIT  = 3;
    localparam int PC_EXTERNAL_INTERRUPT_ONE_BIT     = 6;
    localparam int PC_EXTERNAL_INTERRUPT_TWO_BIT     = 7;

    // ----------------------------------------------------------------
    // Reset values and fixed masks
    // ----------------------------------------------------------------
    localparam logic [7:0] SYSCFG_RST  = 8'h00;
    localparam logic [7:0] PINMUX_RST  = 8'h00;
    localparam logic [7:0] PORT_RST    = 8'h00;
    localparam logic [7:0] PB_SER_OE   = 8'h29;

endpackage : pbc_mux_pkg

// file: src/pbc_mux.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pbc_mux (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Port B pins
    input  wire logic [7:0]  PARALLEL_PORT_B_BITS_IN,
    output logic      [7:0]  PARALLEL_PORT_B_BITS_OUT,
    output logic      [7:0]  PARALLEL_PORT_B_BITS_OE,
    // Port C pins, bits 5 to 0
    input  wire logic [5:0]  PARALLEL_PORT_C_BITS_IN,
    output logic      [5:0]  PARALLEL_PORT_C_BITS_OUT,
    output logic      [5:0]  PARALLEL_PORT_C_BITS_OE,
    // External interrupt pins, active low; capture flags active high
    input  wire logic        EXTERNAL_INTERRUPT_ONE_N,
    input  wire logic        EXTERNAL_INTERRUPT_TWO_N,
    output logic      [1:0]  EXT_INT_CAPTURED,
    // Async channel 0 side
    input  wire logic        ASYNC0_REQUEST_TO_SEND_N,
    input  wire logic        ASYNC0_TRANSMIT,
    output logic             ASYNC0_CLEAR_TO_SEND_N,
    output logic             ASYNC0_CARRIER_DETECT_N,
    output logic             ASYNC0_RECEIVE,
    // Async channel 1 and clocked serial side
    input  wire logic        ASYNC1_TRANSMIT,
    output logic             ASYNC1_RECEIVE,
    output logic             CLOCKED_SERIAL_RX_OR_ASYNC1_CTS,
    // Serial channel A side
    input  wire logic        CHAN_A_REQUEST_TO_SEND_N,
    input  wire logic        CHAN_A_TERMINAL_READY_REQUEST_N,
    input  wire logic        CHAN_A_WAIT_REQUEST_N,
    input  wire logic        CHAN_A_SYNC_OUT_N,
    input  wire logic        CHAN_A_SYNC_OE,
    output logic             CHAN_A_SYNC_IN_N,
    output logic             CHAN_A_CARRIER_DETECT_N,
    output logic             CHAN_A_CLEAR_TO_SEND_N,
    // Processor bus strobe
    input  wire logic        MEMORY_WRITE_STROBE_N
);

    // ----------------------------------------------------------------
    // Registers and synchronisers
    // ----------------------------------------------------------------
    logic [7:0] syscfg_q;
    logic [7:0] pinmux_q;
    logic [7:0] pb_data_q;
    logic [7:0] pb_dir_q;
    logic [5:0] pc_data_q;
    logic [5:0] pc_dir_q;
    logic [1:0] capt_q;
    logic [7:0] pb_s1_q;
    logic [7:0] pb_s2_q;
    logic [5:0] pc_s1_q;
    logic [5:0] pc_s2_q;
    logic [1:0] int_s1_q;
    logic [1:0] int_s2_q;
    logic [1:0] int_prev_q;

    logic       acc;
    logic       wr;
    logic       mapped;
    logic [7:0] rd_d;
    logic [7:0] pb_sel;
    logic [7:0] pb_ser_out;
    logic [5:0] pc_sel;
    logic [5:0] pc_ser_out;
    logic [5:0] pc_ser_oe;
    logic [7:0] pb_out_d;
    logic [7:0] pb_oe_d;
    logic [5:0] pc_out_d;
    logic [5:0] pc_oe_d;
    logic [1:0] fall;
    logic [1:0] clr;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // The answer comes one cycle into the access phase so that read
    // data can leave a flip-flop; every access takes exactly three cycles, setup included.
    assign acc = PSEL & PENABLE & ~PREADY;
    assign wr  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

    always_comb begin
        mapped = 1'b1;
        rd_d   = 8'h00;
        if (PADDR == pbc_mux_pkg::SYSCFG_OFS) begin
            rd_d = syscfg_q;
        end else if (PADDR == pbc_mux_pkg::PINMUX_OFS) begin
            rd_d = pinmux_q;
        end else if (PADDR == pbc_mux_pkg::PB_DATA_OFS) begin
            rd_d = (pb_dir_q & pb_data_q) | (~pb_dir_q & pb_s2_q);
        end else if (PADDR == pbc_mux_pkg::PB_DIR_OFS) begin
            rd_d = pb_dir_q;
        end else if (PADDR == pbc_mux_pkg::PC_DATA_OFS) begin
            // Bits 7 and 6 are input only and show the interrupt pins.
            rd_d = {~int_s2_q[1], ~int_s2_q[0],
                    (pc_dir_q & pc_data_q) | (~pc_dir_q & pc_s2_q)};
        end else if (PADDR == pbc_mux_pkg::PC_DIR_OFS) begin
            rd_d = {2'b00, pc_dir_q};
        end else if (PADDR == pbc_mux_pkg::CAPTURE_OFS) begin
            rd_d = {6'h00, capt_q};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= acc;
            PSLVERR <= acc & ~mapped;
            PRDATA  <= (acc & ~PWRITE) ? {24'h00_0000, rd_d} : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            syscfg_q  <= pbc_mux_pkg::SYSCFG_RST;
            pinmux_q  <= pbc_mux_pkg::PINMUX_RST;
            pb_data_q <= pbc_mux_pkg::PORT_RST;
            pb_dir_q  <= pbc_mux_pkg::PORT_RST;
            pc_data_q <= pbc_mux_pkg::PORT_RST[5:0];
            pc_dir_q  <= pbc_mux_pkg::PORT_RST[5:0];
        end else if (wr) begin
            if (PADDR == pbc_mux_pkg::SYSCFG_OFS) begin
                syscfg_q <= PWDATA[7:0];
            end else if (PADDR == pbc_mux_pkg::PINMUX_OFS) begin
                pinmux_q <= PWDATA[7:0];
            end else if (PADDR == pbc_mux_pkg::PB_DATA_OFS) begin
                pb_data_q <= PWDATA[7:0];
            end else if (PADDR == pbc_mux_pkg::PB_DIR_OFS) begin
                pb_dir_q <= PWDATA[7:0];
            end else if (PADDR == pbc_mux_pkg::PC_DATA_OFS) begin
                pc_data_q <= PWDATA[5:0];
            end else if (PADDR == pbc_mux_pkg::PC_DIR_OFS) begin
                pc_dir_q <= PWDATA[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin input synchronisers and interrupt edge capture
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pb_s1_q    <= 8'hFF;
            pb_s2_q    <= 8'hFF;
            pc_s1_q    <= 6'h3F;
            pc_s2_q    <= 6'h3F;
            int_s1_q   <= 2'b11;
            int_s2_q   <= 2'b11;
            int_prev_q <= 2'b11;
        end else begin
            pb_s1_q    <= PARALLEL_PORT_B_BITS_IN;
            pb_s2_q    <= pb_s1_q;
            pc_s1_q    <= PARALLEL_PORT_C_BITS_IN;
            pc_s2_q    <= pc_s1_q;
            int_s1_q   <= {EXTERNAL_INTERRUPT_TWO_N, EXTERNAL_INTERRUPT_ONE_N};
            int_s2_q   <= int_s1_q;
            int_prev_q <= int_s2_q;
        end
    end

    assign fall = int_prev_q & ~int_s2_q &
                  {pinmux_q[pbc_mux_pkg::MUX_EXTERNAL_INTERRUPT_TWO_EDGE], pinmux_q[pbc_mux_pkg::MUX_EXTERNAL_INTERRUPT_ONE_EDGE]};
    // Only a one clears, and only in edge mode; a new edge in the same
    // cycle still sets the latch.
    assign clr  = (wr && PADDR == pbc_mux_pkg::PC_DATA_OFS) ?
                  ({PWDATA[pbc_mux_pkg::PC_EXTERNAL_INTERRUPT_TWO_BIT], PWDATA[pbc_mux_pkg::PC_EXTERNAL_INTERRUPT_ONE_BIT]} &
                   {pinmux_q[pbc_mux_pkg::MUX_EXTERNAL_INTERRUPT_TWO_EDGE],
                    pinmux_q[pbc_mux_pkg::MUX_EXTERNAL_INTERRUPT_ONE_EDGE]}) : 2'b00;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            capt_q           <= 2'b00;
            EXT_INT_CAPTURED <= 2'b00;
        end else begin
            capt_q           <= fall | (capt_q & ~clr);
            EXT_INT_CAPTURED <= fall | (capt_q & ~clr);
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    assign pb_sel     = {{3{syscfg_q[pbc_mux_pkg::CFG_PB_HI_BIT]}},
                         {5{syscfg_q[pbc_mux_pkg::CFG_PB_LO_BIT]}}};
    assign pb_ser_out = {2'b11, ASYNC1_TRANSMIT, 1'b1, ASYNC0_TRANSMIT, 2'b11,
                         ASYNC0_REQUEST_TO_SEND_N};
    assign pc_sel     = {6{syscfg_q[pbc_mux_pkg::CFG_PC_BIT]}};
    assign pc_ser_out = {CHAN_A_WAIT_REQUEST_N, CHAN_A_SYNC_OUT_N,
                         CHAN_A_TERMINAL_READY_REQUEST_N, CHAN_A_REQUEST_TO_SEND_N,
                         2'b11};
    assign pc_ser_oe  = {1'b1, CHAN_A_SYNC_OE, 2'b11, 2'b00};

    always_comb begin
        pb_out_d = (pb_sel & pb_data_q) | (~pb_sel & pb_ser_out);
        pb_oe_d  = (pb_sel & pb_dir_q) | (~pb_sel & pbc_mux_pkg::PB_SER_OE);
        pc_out_d = (pc_sel & pc_data_q) | (~pc_sel & pc_ser_out);
        pc_oe_d  = (pc_sel & pc_dir_q) | (~pc_sel & pc_ser_oe);
        // The strobe takes the shared pin ahead of the port / RTS pair.
        if (!pinmux_q[pbc_mux_pkg::MUX_STROBE_BIT]) begin
            pc_out_d[2] = MEMORY_WRITE_STROBE_N;
            pc_oe_d[2]  = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PARALLEL_PORT_B_BITS_OUT <= 8'hFF;
            PARALLEL_PORT_B_BITS_OE  <= 8'h00;
            PARALLEL_PORT_C_BITS_OUT <= 6'h3F;
            PARALLEL_PORT_C_BITS_OE  <= 6'h00;
        end else begin
            PARALLEL_PORT_B_BITS_OUT <= pb_out_d;
            PARALLEL_PORT_B_BITS_OE  <= pb_oe_d;
            PARALLEL_PORT_C_BITS_OUT <= pc_out_d;
            PARALLEL_PORT_C_BITS_OE  <= pc_oe_d;
        end
    end

    // ----------------------------------------------------------------
    // Serial-side inputs
    // ----------------------------------------------------------------
    // A pin owned by the parallel port presents an idle, deasserted level
    // to its channel, except channel 0 CTS which is forced active so
    // that the transmitter is never stalled by the port's pin level.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ASYNC0_CLEAR_TO_SEND_N          <= 1'b1;
            ASYNC0_CARRIER_DETECT_N         <= 1'b1;
            ASYNC0_RECEIVE                  <= 1'b1;
            ASYNC1_RECEIVE                  <= 1'b1;
            CLOCKED_SERIAL_RX_OR_ASYNC1_CTS <= 1'b1;
            CHAN_A_CARRIER_DETECT_N         <= 1'b1;
            CHAN_A_CLEAR_TO_SEND_N          <= 1'b1;
            CHAN_A_SYNC_IN_N                <= 1'b1;
        end else begin
            ASYNC0_CLEAR_TO_SEND_N          <= ~pb_sel[1] & pb_s2_q[1];
            ASYNC0_CARRIER_DETECT_N         <= pb_sel[2] | pb_s2_q[2];
            ASYNC0_RECEIVE                  <= pb_sel[4] | pb_s2_q[4];
            ASYNC1_RECEIVE                  <= pb_sel[6] | pb_s2_q[6];
            CLOCKED_SERIAL_RX_OR_ASYNC1_CTS <= pb_sel[7] | pb_s2_q[7];
            CHAN_A_CARRIER_DETECT_N         <= pc_sel[0] | pc_s2_q[0];
            CHAN_A_CLEAR_TO_SEND_N          <= pc_sel[1] | pc_s2_q[1];
            CHAN_A_SYNC_IN_N                <= pc_sel[4] | pc_s2_q[4];
        end
    end

endmodule : pbc_mux

// file: test/pbc_mux_checker.sv
`timescale 1ns/1ps
module pbc_mux_checker (
    // Clock, reset and bus
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    // Pins
    input wire logic [7:0]  PARALLEL_PORT_B_BITS_OUT,
    input wire logic [7:0]  PARALLEL_PORT_B_BITS_OE,
    input wire logic [5:0]  PARALLEL_PORT_C_BITS_OUT,
    input wire logic [5:0]  PARALLEL_PORT_C_BITS_OE,
    // Channel side
    input wire logic        ASYNC0_REQUEST_TO_SEND_N,
    input wire logic        ASYNC0_TRANSMIT,
    input wire logic        ASYNC1_TRANSMIT,
    input wire logic        CHAN_A_REQUEST_TO_SEND_N,
    input wire logic        CHAN_A_SYNC_OE,
    input wire logic        MEMORY_WRITE_STROBE_N,
    input wire logic        ASYNC0_CLEAR_TO_SEND_N
);
    // Mirrors of the select registers, so each check knows the routing in force.
    logic [7:0] cfg_q;
    logic [7:0] mux_q;
    logic [1:0] up_q;
    wire        wr = PSEL && PENABLE && PREADY && PWRITE;
    wire        live = (up_q == 2'h3);
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cfg_q <= 8'h00;
            mux_q <= 8'h00;
            up_q  <= 2'h0;
        end else begin
            if (wr && PADDR == pbc_mux_pkg::SYSCFG_OFS) cfg_q <= PWDATA[7:0];
            if (wr && PADDR == pbc_mux_pkg::PINMUX_OFS) mux_q <= PWDATA[7:0];
            if (!live) up_q <= up_q + 2'h1;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    pb_lo_oe_a: assert property (live && !$past(cfg_q[5]) |->
        PARALLEL_PORT_B_BITS_OE[4:0] == 5'h09) else $error("port B low enables wrong");
    pb_hi_oe_a: assert property (live && !$past(cfg_q[6]) |->
        PARALLEL_PORT_B_BITS_OE[7:5] == 3'h1) else $error("port B high enables wrong");
    pc_oe_a: assert property (live && !$past(cfg_q[7]) |->
        PARALLEL_PORT_C_BITS_OE == {1'b1, $past(CHAN_A_SYNC_OE), 4'hC})
        else $error("port C enables wrong");
    tx0_route_a: assert property (live && !$past(cfg_q[5]) |->
        PARALLEL_PORT_B_BITS_OUT[3] == $past(ASYNC0_TRANSMIT) &&
        PARALLEL_PORT_B_BITS_OUT[0] == $past(ASYNC0_REQUEST_TO_SEND_N))
        else $error("channel 0 outputs not routed");
    tx1_route_a: assert property (live && !$past(cfg_q[6]) |->
        PARALLEL_PORT_B_BITS_OUT[5] == $past(ASYNC1_TRANSMIT)) else $error("tx1 not routed");
    async0_clear_to_send_hold_a: assert property (live && $past(cfg_q[5]) && $past(cfg_q[5], 2) |->
        !ASYNC0_CLEAR_TO_SEND_N) else $error("async0_clear_to_send not held low");
    strobe_pin_a: assert property (live && !$past(mux_q[3]) |->
        PARALLEL_PORT_C_BITS_OE[2] && PARALLEL_PORT_C_BITS_OUT[2] ==
        $past(MEMORY_WRITE_STROBE_N)) else $error("strobe not on pin");
    rts_pin_a: assert property (live && $past(mux_q[3]) && !$past(cfg_q[7]) |->
        PARALLEL_PORT_C_BITS_OUT[2] == $past(CHAN_A_REQUEST_TO_SEND_N))
        else $error("rts not on pin");
endmodule : pbc_mux_checker
bind pbc_mux pbc_mux_checker chk_i (
    .CLOCK                    (CLOCK),
    .RST                      (RST),
    .PSEL                     (PSEL),
    .PENABLE                  (PENABLE),
    .PWRITE                   (PWRITE),
    .PADDR                    (PADDR),
    .PWDATA                   (PWDATA),
    .PREADY                   (PREADY),
    .PARALLEL_PORT_B_BITS_OUT (PARALLEL_PORT_B_BITS_OUT),
    .PARALLEL_PORT_B_BITS_OE  (PARALLEL_PORT_B_BITS_OE),
    .PARALLEL_PORT_C_BITS_OUT (PARALLEL_PORT_C_BITS_OUT),
    .PARALLEL_PORT_C_BITS_OE  (PARALLEL_PORT_C_BITS_OE),
    .ASYNC0_REQUEST_TO_SEND_N (ASYNC0_REQUEST_TO_SEND_N),
    .ASYNC0_TRANSMIT          (ASYNC0_TRANSMIT),
    .ASYNC1_TRANSMIT          (ASYNC1_TRANSMIT),
    .CHAN_A_REQUEST_TO_SEND_N (CHAN_A_REQUEST_TO_SEND_N),
    .CHAN_A_SYNC_OE           (CHAN_A_SYNC_OE),
    .MEMORY_WRITE_STROBE_N    (MEMORY_WRITE_STROBE_N),
    .ASYNC0_CLEAR_TO_SEND_N   (ASYNC0_CLEAR_TO_SEND_N)
);

// file: test/pbc_board.sv
`timescale 1ns/1ps
module pbc_board (
    // Pins from the block
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe,
    input  wire logic [5:0] c_out,
    input  wire logic [5:0] c_oe,
    // Levels the board drives where the block does not
    input  wire logic [7:0] b_drv,
    input  wire logic [5:0] c_drv,
    output logic      [7:0] b_pin,
    output logic      [5:0] c_pin
);
    // Each pin resolves on its own enable, so a wrong direction shows up.
    assign b_pin = (b_oe & b_out) | (~b_oe & b_drv);
    assign c_pin = (c_oe & c_out) | (~c_oe & c_drv);
endmodule : pbc_board

// file: test/tb_port_b_c_pin_multiplexer.sv
`timescale 1ns/1ps
module tb_port_b_c_pin_multiplexer;
    logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
    logic [7:0] PADDR = 8'h00, b_drv = 8'hC6, pb_o, pb_e, pb_p;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [5:0] c_drv = 6'h02, pc_o, pc_e, pc_p;
    logic [8:0] ch = 9'h17F;
    logic external_interrupt_one_n = 1, external_interrupt_two_n = 1, err, async0_clear_to_send, async0_carrier_detect, rx0, rx1, rxs, sin, chan_a_carrier_detect, chan_a_clear_to_send;
    logic [1:0] cap;
    int n_errors = 0, total_checks = 0;
    always #5 CLOCK = ~CLOCK;
    pbc_board board (.b_out(pb_o), .b_oe(pb_e), .c_out(pc_o), .c_oe(pc_e), .b_drv(b_drv),
        .c_drv(c_drv), .b_pin(pb_p), .c_pin(pc_p));
    pbc_mux DUT (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PARALLEL_PORT_B_BITS_IN(pb_p), .PARALLEL_PORT_B_BITS_OUT(pb_o),
        .PARALLEL_PORT_B_BITS_OE(pb_e), .PARALLEL_PORT_C_BITS_IN(pc_p),
        .PARALLEL_PORT_C_BITS_OUT(pc_o), .PARALLEL_PORT_C_BITS_OE(pc_e),
        .EXTERNAL_INTERRUPT_ONE_N(external_interrupt_one_n), .EXTERNAL_INTERRUPT_TWO_N(external_interrupt_two_n),
        .EXT_INT_CAPTURED(cap), .ASYNC0_REQUEST_TO_SEND_N(ch[0]), .ASYNC0_TRANSMIT(ch[1]),
        .ASYNC0_CLEAR_TO_SEND_N(async0_clear_to_send), .ASYNC0_CARRIER_DETECT_N(async0_carrier_detect), .ASYNC0_RECEIVE(rx0),
        .ASYNC1_TRANSMIT(ch[2]), .ASYNC1_RECEIVE(rx1), .CLOCKED_SERIAL_RX_OR_ASYNC1_CTS(rxs),
        .CHAN_A_REQUEST_TO_SEND_N(ch[3]), .CHAN_A_TERMINAL_READY_REQUEST_N(ch[4]),
        .CHAN_A_WAIT_REQUEST_N(ch[5]), .CHAN_A_SYNC_OUT_N(ch[6]), .CHAN_A_SYNC_OE(ch[7]),
        .CHAN_A_SYNC_IN_N(sin), .CHAN_A_CARRIER_DETECT_N(chan_a_carrier_detect), .CHAN_A_CLEAR_TO_SEND_N(chan_a_clear_to_send),
        .MEMORY_WRITE_STROBE_N(ch[8]));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task stop_test;
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Called just after a rising edge; one idle cycle follows so the next call never
    // assigns the strobes in the same time step as this release.
    // A slave that never answers is left to the watchdog, which fails the run.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask : apb
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        apb(pbc_mux_pkg::SYSCFG_OFS, 0, 0);
        chk("syscfg", 32'h0, rd);
        chk("pb oe", 32'h29, pb_e);
        chk("pc oe", 32'h2C, pc_e);
    endtask : t_reset
    task t_serial;
        ch <= 9'h0AA;
        repeat (5) @(posedge CLOCK);
        chk("async in", 32'h1B, {rxs, rx1, rx0, async0_carrier_detect, async0_clear_to_send});
        chk("chan a in", 32'h2, {sin, chan_a_clear_to_send, chan_a_carrier_detect});
        chk("pb out", 32'h08, pb_o & 8'h29);
        chk("pc out", 32'h20, pc_o & 6'h3C);
        apb(pbc_mux_pkg::PINMUX_OFS, 1, 32'h08);
        // The pin register takes the new select one edge after the write edge.
        @(posedge CLOCK);
        chk("rts pin", 32'h1, pc_o[2]);
    endtask : t_serial
    task t_port;
        external_interrupt_two_n <= 0;
        apb(pbc_mux_pkg::SYSCFG_OFS, 1, 32'hE0);
        apb(pbc_mux_pkg::PB_DIR_OFS, 1, 32'h0F);
        apb(pbc_mux_pkg::PB_DATA_OFS, 1, 32'hA7);
        apb(pbc_mux_pkg::PC_DIR_OFS, 1, 32'h30);
        apb(pbc_mux_pkg::PC_DATA_OFS, 1, 32'h15);
        chk("port oe", 32'h0F30, {pb_e, 2'b00, pc_e});
        // Port B bit 1 drives a one here, so only the forcing can give a low.
        chk("async0_clear_to_send held", 32'h0, async0_clear_to_send);
        chk("idle inputs", 32'h7F, {rxs, rx1, rx0, async0_carrier_detect, sin, chan_a_clear_to_send, chan_a_carrier_detect});
        apb(pbc_mux_pkg::PB_DATA_OFS, 0, 0);
        chk("pb read", 32'hC7, rd);
        apb(pbc_mux_pkg::PC_DATA_OFS, 0, 0);
        chk("pc read", 32'h92, rd);
        apb(8'h1C, 0, 0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, err);
    endtask : t_port
    task t_capture;
        external_interrupt_two_n <= 1;
        apb(pbc_mux_pkg::PINMUX_OFS, 1, 32'h0B);
        external_interrupt_one_n <= 0;
        external_interrupt_two_n <= 0;
        repeat (6) @(posedge CLOCK);
        chk("latched", 32'h3, cap);
        apb(pbc_mux_pkg::PC_DATA_OFS, 1, 32'h15);
        chk("zero kept", 32'h3, cap);
        apb(pbc_mux_pkg::PC_DATA_OFS, 1, 32'h55);
        chk("one clears", 32'h2, cap);
        apb(pbc_mux_pkg::CAPTURE_OFS, 0, 0);
        chk("capture reg", 32'h2, rd);
        // With edge mode off a one in bit 7 must leave the latch alone.
        apb(pbc_mux_pkg::PINMUX_OFS, 1, 32'h08);
        apb(pbc_mux_pkg::PC_DATA_OFS, 1, 32'h95);
        chk("level kept", 32'h2, cap);
    endtask : t_capture
    initial begin
        repeat (10) @(posedge CLOCK);
        RST <= 0;
        @(posedge CLOCK);
        t_reset;
        t_serial;
        t_port;
        t_capture;
        stop_test;
    end
    initial begin
        repeat (3000) @(posedge CLOCK);
        n_errors++;
        stop_test;
    end
endmodule : tb_port_b_c_pin_multiplexer
